// *** src/pcicfg_pkg.sv ***
// Constants of the configuration header: offsets, field positions, fixed values.
// Assumes byte offsets on the configuration side, one aligned dword per register.
package pcicfg_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_IDENT = 8'h00;
	localparam logic [7:0] OFF_CMD = 8'h04;
	localparam logic [7:0] OFF_REV = 8'h08;
	localparam logic [7:0] OFF_HDR = 8'h0C;
	localparam logic [7:0] OFF_BAR = 8'h10;
	localparam logic [7:0] OFF_INTR = 8'h3C;
	localparam logic [7:0] OFF_LIMIT = 8'h40;
	// Command field positions
	localparam int CMD_IO_EN = 0;
	localparam int CMD_MEM_EN = 1;
	localparam int CMD_PAR_EN = 6;
	localparam int CMD_WAIT = 7;
	localparam int CMD_SERR_EN = 8;
	// Status field positions
	localparam int ST_MDPE = 24;
	localparam int ST_DEVSEL_LO = 25;
	localparam int ST_SERR_GEN = 30;
	localparam int ST_PAR_DET = 31;
	localparam logic [1:0] DEVSEL_SLOW = 2'h2;
	// Fixed values
	localparam logic [23:0] CLASS_CODE = 24'h060500;
	localparam logic [31:0] HDR_WORD = 32'h00000000;
	localparam logic [1:0] BAR_IO_BITS = 2'h1;
	localparam logic [7:0] INT_PIN = 8'h01;
	localparam logic [7:0] MIN_GNT = 8'h00;
	localparam logic [7:0] MAX_LAT = 8'h00;
	// Reset values
	localparam logic CMD_BIT_RST = 1'b0;
	localparam logic [29:0] BAR_BASE_RST = 30'h00000000;
	localparam logic [7:0] INT_LINE_RST = 8'h00;
	// Socket B register index step
	localparam logic [6:0] SOCK_B_STEP = 7'h40;
	// Byte within the operation dword
	localparam logic [1:0] OP_INDEX_BYTE = 2'h0;
	localparam logic [1:0] OP_DATA_BYTE = 2'h1;
endpackage

// *** src/pcicfg_sticky.sv ***
// Sticky event flag, cleared by software, set wins over clear.
// Assumes set and clear are single-cycle strobes on clk.
`timescale 1ns/100ps
module pcicfg_sticky
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic set,
	input wire logic clr,
	output logic flag_q
);
	// Event in the clearing cycle must not be lost
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			flag_q <= 1'b0;
		else if (set)
			flag_q <= 1'b1;
		else if (clr)
			flag_q <= 1'b0;
	end
endmodule

// *** src/pcicfg_io_dec.sv ***
// Decoder for the operation register dword in I/O space.
// Assumes io_addr is a byte address valid while io_req is high.
`timescale 1ns/100ps
module pcicfg_io_dec
(
	input wire logic io_en,
	input wire logic [29:0] base,
	input wire logic io_req,
	input wire logic [31:0] io_addr,
	output logic claim,
	output logic index_sel,
	output logic data_sel
);
	// Upper two bytes of the dword are claimed but ignored
	always_comb
	begin
		claim = io_en && io_req && (io_addr[31:2] == base);
		index_sel = claim && (io_addr[1:0] == pcicfg_pkg::OP_INDEX_BYTE);
		data_sel = claim && (io_addr[1:0] == pcicfg_pkg::OP_DATA_BYTE);
	end
endmodule

// *** src/pcicfg_regs.sv ***
// Configuration header register bank of the dual-socket card adapter.
// Assumes a PCI target front end that strobes config accesses and flags
// parity errors as same-clock pulses; SERR# is resolved by the pad.
`timescale 1ns/100ps
module pcicfg_regs
#(
	// Arbitrary identity values
	parameter logic [15:0] VENDOR_CODE = 16'hA5A5,
	parameter logic [15:0] DEVICE_CODE = 16'h5A5A,
	parameter logic [7:0] REV_CODE = 8'h00
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cfg_sel,
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_ack,
	input wire logic io_req,
	input wire logic [31:0] io_addr,
	output logic io_claim,
	output logic io_index_sel,
	output logic io_data_sel,
	input wire logic io_win_hit,
	output logic io_win_claim,
	input wire logic mem_win_hit,
	output logic mem_claim,
	input wire logic addr_par_err,
	input wire logic data_par_err,
	output logic par_check_en,
	output logic serr_n_out,
	output logic serr_oe,
	input wire logic sock_b,
	input wire logic [5:0] sock_reg,
	output logic [6:0] sock_index
);
	logic cmd_io_q;
	logic cmd_mem_q;
	logic cmd_par_q;
	logic cmd_serr_q;
	logic [29:0] bar_base_q;
	logic [7:0] int_line_q;
	logic st_serr_q;
	logic st_par_q;
	logic serr_q;
	logic [31:0] rd_d;
	logic [31:0] cmd_word;
	logic in_range;
	logic wr_stb;
	logic wr_cmd;
	logic wr_bar;
	logic wr_intr;
	logic serr_event;
	logic clr_serr;
	logic clr_par;

	// Only dwords below 40h are decoded; above reads zero
	assign in_range = (cfg_addr < pcicfg_pkg::OFF_LIMIT);
	assign wr_stb = cfg_sel && cfg_wr && in_range;
	assign wr_cmd = wr_stb && (cfg_addr[7:2] == pcicfg_pkg::OFF_CMD[7:2]);
	assign wr_bar = wr_stb && (cfg_addr[7:2] == pcicfg_pkg::OFF_BAR[7:2]);
	assign wr_intr = wr_stb && (cfg_addr[7:2] == pcicfg_pkg::OFF_INTR[7:2]);

	// Command enables; fixed bits are never stored
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cmd_io_q <= pcicfg_pkg::CMD_BIT_RST;
			cmd_mem_q <= pcicfg_pkg::CMD_BIT_RST;
			cmd_par_q <= pcicfg_pkg::CMD_BIT_RST;
			cmd_serr_q <= pcicfg_pkg::CMD_BIT_RST;
		end
		else if (wr_cmd)
		begin
			if (cfg_be[0])
			begin
				cmd_io_q <= cfg_wdata[pcicfg_pkg::CMD_IO_EN];
				cmd_mem_q <= cfg_wdata[pcicfg_pkg::CMD_MEM_EN];
				cmd_par_q <= cfg_wdata[pcicfg_pkg::CMD_PAR_EN];
			end
			if (cfg_be[1])
				cmd_serr_q <= cfg_wdata[pcicfg_pkg::CMD_SERR_EN];
		end
	end

	// Base address: low two bits are constants, not storage
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			bar_base_q <= pcicfg_pkg::BAR_BASE_RST;
		else if (wr_bar)
		begin
			if (cfg_be[0])
				bar_base_q[5:0] <= cfg_wdata[7:2];
			if (cfg_be[1])
				bar_base_q[13:6] <= cfg_wdata[15:8];
			if (cfg_be[2])
				bar_base_q[21:14] <= cfg_wdata[23:16];
			if (cfg_be[3])
				bar_base_q[29:22] <= cfg_wdata[31:24];
		end
	end

	// Interrupt line: storage only, deliberately not routed anywhere
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			int_line_q <= pcicfg_pkg::INT_LINE_RST;
		else if (wr_intr && cfg_be[0])
			int_line_q <= cfg_wdata[7:0];
	end

	// Parity error reporting
	assign par_check_en = cmd_par_q;
	assign serr_event = addr_par_err && cmd_par_q && cmd_serr_q;
	assign clr_serr = wr_cmd && cfg_be[3] && cfg_wdata[pcicfg_pkg::ST_SERR_GEN];
	assign clr_par = wr_cmd && cfg_be[3] && cfg_wdata[pcicfg_pkg::ST_PAR_DET];

	// SERR# held low for one clock per event
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			serr_q <= 1'b0;
		else
			serr_q <= serr_event;
	end
	assign serr_n_out = 1'b0;
	assign serr_oe = serr_q;

	pcicfg_sticky u_st_serr
	(
		.clk(clk),
		.rst_n(rst_n),
		.set(serr_event),
		.clr(clr_serr),
		.flag_q(st_serr_q)
	);

	// Detection flag ignores the parity enable on purpose
	pcicfg_sticky u_st_par
	(
		.clk(clk),
		.rst_n(rst_n),
		.set(addr_par_err || data_par_err),
		.clr(clr_par),
		.flag_q(st_par_q)
	);

	// I/O decode for the index and data bytes
	pcicfg_io_dec u_io_dec
	(
		.io_en(cmd_io_q),
		.base(bar_base_q),
		.io_req(io_req),
		.io_addr(io_addr),
		.claim(io_claim),
		.index_sel(io_index_sel),
		.data_sel(io_data_sel)
	);

	assign io_win_claim = io_win_hit && cmd_io_q;
	assign mem_claim = mem_win_hit && cmd_mem_q;

	// Socket register index; socket B offset by one step
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			sock_index <= 7'h00;
		else if (sock_b)
			sock_index <= {1'b0, sock_reg} + pcicfg_pkg::SOCK_B_STEP;
		else
			sock_index <= {1'b0, sock_reg};
	end

	// Command/status word; reserved 29-27 read zero
	always_comb
	begin
		cmd_word = 32'h00000000;
		cmd_word[pcicfg_pkg::CMD_IO_EN] = cmd_io_q;
		cmd_word[pcicfg_pkg::CMD_MEM_EN] = cmd_mem_q;
		cmd_word[pcicfg_pkg::CMD_PAR_EN] = cmd_par_q;
		cmd_word[pcicfg_pkg::CMD_WAIT] = 1'b1;
		cmd_word[pcicfg_pkg::CMD_SERR_EN] = cmd_serr_q;
		cmd_word[pcicfg_pkg::ST_MDPE] = 1'b0;
		cmd_word[pcicfg_pkg::ST_DEVSEL_LO +: 2] = pcicfg_pkg::DEVSEL_SLOW;
		cmd_word[pcicfg_pkg::ST_SERR_GEN] = st_serr_q;
		cmd_word[pcicfg_pkg::ST_PAR_DET] = st_par_q;
	end

	// Read mux
	always_comb
	begin
		rd_d = 32'h00000000;
		if (in_range)
		begin
			case (cfg_addr[7:2])
				pcicfg_pkg::OFF_IDENT[7:2]: rd_d = {DEVICE_CODE, VENDOR_CODE};
				pcicfg_pkg::OFF_CMD[7:2]: rd_d = cmd_word;
				pcicfg_pkg::OFF_REV[7:2]: rd_d = {pcicfg_pkg::CLASS_CODE, REV_CODE};
				pcicfg_pkg::OFF_HDR[7:2]: rd_d = pcicfg_pkg::HDR_WORD;
				pcicfg_pkg::OFF_BAR[7:2]: rd_d = {bar_base_q, pcicfg_pkg::BAR_IO_BITS};
				pcicfg_pkg::OFF_INTR[7:2]:
					rd_d = {pcicfg_pkg::MAX_LAT, pcicfg_pkg::MIN_GNT,
						pcicfg_pkg::INT_PIN, int_line_q};
				default: rd_d = 32'h00000000;
			endcase
		end
	end

	// Answer one clock after the strobe; writes return the old value
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfg_ack <= 1'b0;
			cfg_rdata <= 32'h00000000;
		end
		else
		begin
			cfg_ack <= cfg_sel;
			if (cfg_sel)
				cfg_rdata <= rd_d;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	AST_ACK_TIMING: assert property (cfg_sel |=> cfg_ack)
		else $error("config strobe not answered next cycle");
	AST_IDENT_RO: assert property (
		cfg_sel && !cfg_wr && cfg_addr == pcicfg_pkg::OFF_IDENT
		|=> cfg_rdata == {DEVICE_CODE, VENDOR_CODE})
		else $error("identity word wrong");
	AST_IO_GATED: assert property (!cmd_io_q |-> !io_claim && !io_win_claim)
		else $error("I/O claimed while disabled");
	AST_MEM_GATED: assert property (mem_claim |-> cmd_mem_q && mem_win_hit)
		else $error("memory claimed while disabled");
	AST_SERR_CAUSE: assert property (
		serr_oe |-> $past(addr_par_err && cmd_par_q && cmd_serr_q))
		else $error("SERR# without enabled address parity error");
	AST_SERR_SETS_STATUS: assert property (serr_oe |-> st_serr_q)
		else $error("SERR# status not set");
	AST_PAR_DET: assert property ((addr_par_err || data_par_err) |=> st_par_q)
		else $error("parity detected flag missed");
	AST_CMD_FIXED: assert property (
		cfg_sel && !cfg_wr && cfg_addr == pcicfg_pkg::OFF_CMD
		|=> cfg_rdata[7] && !cfg_rdata[24] && cfg_rdata[26:25] == 2'h2)
		else $error("fixed command/status bits wrong");
	AST_BAR_LOW: assert property (
		cfg_sel && !cfg_wr && cfg_addr == pcicfg_pkg::OFF_BAR
		|=> cfg_rdata[1:0] == 2'h1)
		else $error("base address low bits wrong");
	AST_STATUS_ONLY_EVENT: assert property (
		$rose(st_par_q) |-> $past(addr_par_err || data_par_err))
		else $error("status set without event");
	AST_SOCK_STEP: assert property (
		sock_b |=> sock_index == {1'b1, $past(sock_reg)})
		else $error("socket B index not offset by 40h");
	AST_SOCK_A: assert property (
		!sock_b |=> sock_index == {1'b0, $past(sock_reg)})
		else $error("socket A index altered");

	// SERR# needs both enables and an address parity error
	AST_PAR_GATES_SERR: assert property (
		!cmd_par_q |=> !serr_oe)
		else $error("SERR# raised with parity checking off");
	AST_SERR_NEEDS_EN: assert property (
		!cmd_serr_q |=> !serr_oe)
		else $error("SERR# raised with system error reporting off");
	AST_DATA_NO_SERR: assert property (
		data_par_err && !addr_par_err |=> !serr_oe)
		else $error("SERR# raised on data parity error");
	AST_SERR_ON_EVENT: assert property (
		addr_par_err && cmd_par_q && cmd_serr_q |=> serr_oe)
		else $error("SERR# missed on enabled address parity error");
	AST_SERR_ST_RISE: assert property (
		$rose(st_serr_q) |-> serr_oe)
		else $error("SERR# status set without SERR#");
	AST_PAR_IGNORES_EN: assert property (
		data_par_err && !cmd_par_q |=> st_par_q)
		else $error("parity detected flag gated by enable");

	// Status flags clear only on a written one, and only without a new event
	AST_W1C_SERR: assert property (
		clr_serr && !serr_event |=> !st_serr_q)
		else $error("SERR# status not cleared by written one");
	AST_W1C_PAR: assert property (
		clr_par && !addr_par_err && !data_par_err |=> !st_par_q)
		else $error("parity status not cleared by written one");
	AST_W0_KEEPS: assert property (
		wr_cmd && !cfg_wdata[pcicfg_pkg::ST_PAR_DET] && st_par_q |=> st_par_q)
		else $error("parity status lost on written zero");

	AST_REV_CLASS: assert property (
		cfg_sel && !cfg_wr && cfg_addr == pcicfg_pkg::OFF_REV
		|=> cfg_rdata == {pcicfg_pkg::CLASS_CODE, REV_CODE})
		else $error("revision and class word wrong");
	AST_HDR_ZERO: assert property (
		cfg_sel && !cfg_wr && cfg_addr == pcicfg_pkg::OFF_HDR
		|=> cfg_rdata == 32'h00000000)
		else $error("cache line, latency, header or self-test not zero");
	AST_INTR_FIXED: assert property (
		cfg_sel && !cfg_wr && cfg_addr == pcicfg_pkg::OFF_INTR
		|=> cfg_rdata[31:8] == 24'h000001)
		else $error("interrupt pin or latency bytes wrong");
	AST_INT_LINE_HOLD: assert property (
		!(wr_intr && cfg_be[0]) |=> $stable(int_line_q))
		else $error("interrupt line changed without a write");
	AST_OUT_OF_RANGE: assert property (
		cfg_sel && !cfg_wr && !in_range |=> cfg_rdata == 32'h00000000)
		else $error("read above header not zero");
	AST_IO_DATA_BYTE: assert property (
		cmd_io_q && io_req && io_addr == {bar_base_q, pcicfg_pkg::OP_DATA_BYTE}
		|-> io_data_sel && !io_index_sel)
		else $error("data byte not decoded at base plus one");

	COV_SERR: cover property (serr_oe ##1 clr_serr);
	COV_PAR_NO_SERR: cover property (data_par_err ##1 st_par_q && !serr_oe);
	COV_SOCK_B: cover property (sock_b ##1 sock_index[6]);
	COV_IO_DATA: cover property (io_index_sel ##[1:4] io_data_sel);
	COV_CMD_WR: cover property (wr_cmd && cfg_wdata[0] ##1 cmd_io_q);
endmodule

// *** verif/pcicfg_host_bfm.sv ***
// Host bridge model issuing configuration reads and writes.
// Assumes the one-cycle registered ack of the bank, sampled at the falling edge.
`timescale 1ns/100ps
module pcicfg_host_bfm
(
	input wire logic clk,
	output logic cfg_sel,
	output logic cfg_wr,
	output logic [7:0] cfg_addr,
	output logic [3:0] cfg_be,
	output logic [31:0] cfg_wdata,
	input wire logic [31:0] cfg_rdata,
	input wire logic cfg_ack
);
	initial
	begin
		cfg_sel = 1'b0;
		cfg_wr = 1'b0;
		cfg_addr = 8'hFF;
		cfg_be = 4'h0;
		cfg_wdata = 32'h0;
	end
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d, output logic [31:0] q, output logic ack);
		logic [31:0] dw;
		dw = d;
		if (a[7:2] == pcicfg_pkg::OFF_CMD[7:2])
			dw[29:27] = 3'h0;
		@(posedge clk);
		cfg_sel <= 1'b1;
		cfg_wr <= wr;
		cfg_addr <= a;
		cfg_be <= be;
		cfg_wdata <= dw;
		@(posedge clk);
		// Released lines carry garbage so stale values never pass
		cfg_sel <= 1'b0;
		cfg_wr <= ~wr;
		cfg_addr <= ~a;
		cfg_be <= ~be;
		cfg_wdata <= ~dw;
		@(negedge clk);
		q = cfg_rdata;
		ack = cfg_ack;
	endtask
endmodule

// *** verif/tb.sv ***
// Self-checking bench of the configuration register bank.
// Assumes the host model drives the config port; other inputs are driven here.
`timescale 1ns/100ps
module tb;
	localparam logic [15:0] VEN = 16'h3C3C; // Arbitrary code
	localparam logic [15:0] DEV = 16'hC3C3; // Arbitrary code
	localparam logic [7:0] REV = 8'h2B;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cfg_sel, cfg_wr, cfg_ack, io_claim, io_index_sel, io_data_sel, io_win_claim;
	logic mem_claim, par_check_en, serr_n_out, serr_oe, io_req, io_win_hit, mem_win_hit;
	logic addr_par_err, data_par_err, sock_b;
	logic [7:0] cfg_addr;
	logic [3:0] cfg_be, cm;
	logic [31:0] cfg_wdata, cfg_rdata, io_addr, q, d, base;
	logic [5:0] sock_reg;
	logic [6:0] sock_index;
	logic [7:0] offs [6] = '{8'h00, 8'h08, 8'h0C, 8'h40, 8'h7C, 8'hFC};
	integer seed, n_fail, n_tests, i, j, k;
	always #25 clk = ~clk;
	pcicfg_host_bfm host (.clk, .cfg_sel, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata,
		.cfg_rdata, .cfg_ack);
	pcicfg_regs #(.VENDOR_CODE(VEN), .DEVICE_CODE(DEV), .REV_CODE(REV)) DUT (.clk, .rst_n,
		.cfg_sel, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_ack, .io_req,
		.io_addr, .io_claim, .io_index_sel, .io_data_sel, .io_win_hit, .io_win_claim,
		.mem_win_hit, .mem_claim, .addr_par_err, .data_par_err, .par_check_en, .serr_n_out,
		.serr_oe, .sock_b, .sock_reg, .sock_index);
	task automatic final_report;
		$display("Comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests = n_tests + 1;
		if (got !== exp)
		begin
			n_fail = n_fail + 1;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cfg(input logic wr, input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] dd);
		logic ak;
		host.xfer(wr, a, be, dd, q, ak);
		chk({31'h0, ak}, 32'h1);
	endtask
	// Status bits 29-27 read zero; reads are still masked there before the compare
	function automatic logic [31:0] exp_cs(input logic [3:0] c, input logic [1:0] s);
		logic [31:0] v;
		v = {s, 3'h0, 2'h2, 16'h0, c[3], 1'b1, c[2], 4'h0, c[1:0]};
		return v;
	endfunction
	function automatic logic [31:0] cmdw(input logic [3:0] c);
		return {23'h0, c[3], 1'b0, c[2], 4'h0, c[1:0]};
	endfunction
	function automatic logic [31:0] fixw(input logic [7:0] a);
		if (a == 8'h00)
			return {DEV, VEN};
		if (a == 8'h08)
			return {24'h060500, REV};
		return 32'h0;
	endfunction
	task automatic pulse(input logic isaddr);
		@(posedge clk);
		addr_par_err <= isaddr;
		data_par_err <= ~isaddr;
		@(posedge clk);
		addr_par_err <= 1'b0;
		data_par_err <= 1'b0;
		@(negedge clk);
	endtask
	initial
	begin
		seed = 32'hcc6fc059;
		n_fail = 0;
		n_tests = 0;
		{io_req, io_win_hit, mem_win_hit, addr_par_err, data_par_err, sock_b} = 6'h0;
		io_addr = 32'h0;
		sock_reg = 6'h0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		cfg(1'b0, pcicfg_pkg::OFF_CMD, 4'hF, 32'h0);
		chk(q & 32'hC7FFFFFF, exp_cs(4'h0, 2'h0));
		for (i = 0; i < 2; i++)
			for (j = 0; j < 6; j++)
			begin
				if (i == 1)
					cfg(1'b1, offs[j], 4'hF, $random(seed));
				cfg(1'b0, offs[j], 4'hF, 32'h0);
				chk(q, fixw(offs[j]));
			end
		d = $random(seed);
		cfg(1'b1, pcicfg_pkg::OFF_INTR, 4'hF, d);
		cfg(1'b0, pcicfg_pkg::OFF_INTR, 4'hF, 32'h0);
		chk(q, {16'h0001, d[7:0]});
		base = {$random(seed)} & 32'hFFFFFFF0;
		cfg(1'b1, pcicfg_pkg::OFF_BAR, 4'hF, base);
		cfg(1'b0, pcicfg_pkg::OFF_BAR, 4'hF, 32'h0);
		chk(q, base | 32'h1);
		for (k = 0; k < 4; k++)
		begin
			cm = {2'h0, k[1:0]};
			cfg(1'b1, pcicfg_pkg::OFF_CMD, 4'h3, cmdw(cm));
			for (j = 0; j < 5; j++)
			begin
				@(posedge clk);
				io_req <= 1'b1;
				io_addr <= base + j;
				io_win_hit <= 1'b1;
				mem_win_hit <= 1'b1;
				@(negedge clk);
				chk({io_claim, io_index_sel, io_data_sel, io_win_claim, mem_claim},
					{cm[0] && j < 4, cm[0] && j == 0, cm[0] && j == 1, cm[0], cm[1]});
			end
			@(posedge clk);
			{io_req, io_win_hit, mem_win_hit} <= 3'h0;
		end
		for (k = 0; k < 5; k++)
		begin
			cm = (k == 4) ? 4'hC : {k[1:0], 2'h0};
			cfg(1'b1, pcicfg_pkg::OFF_CMD, 4'h3, cmdw(cm));
			chk({31'h0, par_check_en}, {31'h0, cm[2]});
			pulse(k < 4);
			chk({30'h0, serr_oe, serr_n_out}, {30'h0, k < 4 && cm[3:2] == 2'h3, 1'b0});
			cfg(1'b1, pcicfg_pkg::OFF_CMD, 4'hF, cmdw(cm));
			cfg(1'b0, pcicfg_pkg::OFF_CMD, 4'hF, 32'h0);
			chk(q & 32'hC7FFFFFF, exp_cs(cm, {1'b1, k < 4 && cm[3:2] == 2'h3}));
			cfg(1'b1, pcicfg_pkg::OFF_CMD, 4'h8, 32'hC0000000);
			cfg(1'b1, pcicfg_pkg::OFF_CMD, 4'h8, 32'hC0000000);
			cfg(1'b0, pcicfg_pkg::OFF_CMD, 4'hF, 32'h0);
			chk(q & 32'hC7FFFFFF, exp_cs(cm, 2'h0));
		end
		for (i = 0; i < 24; i++)
		begin
			d = $random(seed);
			@(posedge clk);
			sock_b <= d[6];
			sock_reg <= d[5:0];
			@(posedge clk);
			@(negedge clk);
			chk({25'h0, sock_index}, {25'h0, 1'b0, d[5:0]} + (d[6] ? 32'h40 : 32'h0));
		end
		final_report;
	end
	initial
	begin
		repeat (5000) @(posedge clk);
		n_fail = n_fail + 1;
		final_report;
	end
endmodule
